// file: imnd_decode.sv
// Decode and execute of the direct store, indirect store and no-operation instructions.
//
// Operation
// (RQ1) The indirect store copies the working register to the location the chosen pointer names, mode 10 then increments and mode 11 then decrements the pointer.
// (RQ2) The indirect access registers hold nothing and any access to one goes to the data memory location held in the matching pointer.
// (RQ3) Each pointer is 16 bits wide and wraps silently past FFFFh or below 0000h.
// (RQ4) The direct store writes the working register to file register 0 to 127 in one word and one cycle, leaving status untouched.
// (RQ5) Mode 00 addresses pointer plus one and mode 01 pointer minus one, and the relative form addresses pointer plus a signed offset of -32 to 31 without changing the pointer.
// (RQ6) The no-operation takes one word and one cycle and only advances the program counter.
`timescale 1ns/1ps
`include "imnd_consts.svh"

module imnd_decode (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Instruction from the fetch stage with the current working register.
  input wire imnd_pkg::imnd_instr_t instr_i,
  // Pointer load from other instructions of the core.
  input wire imnd_pkg::imnd_ptr_load_t ptr_ld_i,
  // Data memory and file register write.
  output imnd_pkg::imnd_mem_wr_t wr_o,
  // Program counter advance and pointer readback.
  output logic pc_inc_o,
  output logic [`IMND_PTR_W-1:0] ptr0_o,
  output logic [`IMND_PTR_W-1:0] ptr1_o
);
  import imnd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  function automatic imnd_kind_t kind_of(input logic [`IMND_WORD_W-1:0] word);
    imnd_kind_t k;
    k = IMND_OTHER;
    if (word == `IMND_NOOP_WORD)
      k = IMND_NOOP;
    else if (word[`IMND_DIRECT_MSB:`IMND_DIRECT_LSB] == `IMND_DIRECT_PFX)
      k = IMND_DIRECT;
    else if (word[`IMND_INDMODE_MSB:`IMND_INDMODE_LSB] == `IMND_INDMODE_PFX)
      k = IMND_INDMODE;
    else if (word[`IMND_DIRECT_MSB:`IMND_DIRECT_LSB] == `IMND_RELATIVE_PFX)
      k = IMND_RELATIVE;
    return k;
  endfunction

  // Sixteen-bit arithmetic drops the carry, so the pointer wraps with no fault.
  function automatic logic [`IMND_PTR_W-1:0] ptr_add(input logic [`IMND_PTR_W-1:0] p,
                                                     input logic [`IMND_PTR_W-1:0] d);
    return p + d; // RQ3
  endfunction

  function automatic logic [`IMND_PTR_W-1:0] sext_off(input logic [`IMND_OFFSET_W-1:0] k);
    return {{(`IMND_PTR_W-`IMND_OFFSET_W){k[`IMND_OFFSET_W-1]}}, k};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  logic [`IMND_PTR_W-1:0] ptr_q [2];
  logic [`IMND_PTR_W-1:0] ptr_d [2];
  imnd_mem_wr_t wr_q;
  imnd_mem_wr_t wr_d;
  logic pc_inc_q;
  logic pc_inc_d;

  imnd_kind_t kind;
  logic sel;
  logic [1:0] mode;
  logic [`IMND_PTR_W-1:0] cur;
  logic [`IMND_PTR_W-1:0] upd;
  logic [`IMND_FILE_W-1:0] faddr;

  always_comb
  begin
    ptr_d[0] = ptr_q[0];
    ptr_d[1] = ptr_q[1];
    wr_d = '0;
    pc_inc_d = 1'b0;
    kind = instr_i.valid ? kind_of(instr_i.word) : IMND_OTHER;
    mode = instr_i.word[1:0];
    faddr = instr_i.word[`IMND_FILE_W-1:0];
    sel = (kind == IMND_RELATIVE) ? instr_i.word[`IMND_RELATIVE_SEL_BIT]
                                  : instr_i.word[`IMND_INDMODE_SEL_BIT];
    cur = ptr_q[sel];
    upd = cur;
    wr_d.data = instr_i.w_val;
    case (kind)
      IMND_NOOP:
      begin
        pc_inc_d = 1'b1; // RQ6
      end
      IMND_DIRECT:
      begin
        pc_inc_d = 1'b1;
        wr_d.we = 1'b1; // RQ4
        if (faddr == `IMND_ALIAS0_ADDR)
        begin
          wr_d.addr = ptr_q[0]; // RQ2
        end
        else if (faddr == `IMND_ALIAS1_ADDR)
        begin
          wr_d.addr = ptr_q[1]; // RQ2
        end
        else
        begin
          wr_d.file_space = 1'b1;
          wr_d.addr = {{(`IMND_PTR_W-`IMND_FILE_W){1'b0}}, faddr}; // RQ4
        end
      end
      IMND_INDMODE:
      begin
        pc_inc_d = 1'b1;
        wr_d.we = 1'b1;
        case (mode)
          `IMND_MODE_PREINC:
          begin
            upd = ptr_add(cur, `IMND_PTR_ONE); // RQ5
            wr_d.addr = upd;
          end
          `IMND_MODE_PREDEC:
          begin
            upd = ptr_add(cur, ~`IMND_PTR_RESET); // RQ5
            wr_d.addr = upd;
          end
          `IMND_MODE_POSTINC:
          begin
            wr_d.addr = cur; // RQ1
            upd = ptr_add(cur, `IMND_PTR_ONE);
          end
          default:
          begin
            wr_d.addr = cur; // RQ1
            upd = ptr_add(cur, ~`IMND_PTR_RESET);
          end
        endcase
        ptr_d[sel] = upd;
      end
      IMND_RELATIVE:
      begin
        pc_inc_d = 1'b1;
        wr_d.we = 1'b1;
        wr_d.addr = ptr_add(cur, sext_off(instr_i.word[`IMND_OFFSET_W-1:0])); // RQ5
      end
      default:
      begin
        wr_d.data = '0;
      end
    endcase
    // A core load of a pointer overrides an update in the same cycle.
    if (ptr_ld_i.valid)
    begin
      ptr_d[ptr_ld_i.sel] = ptr_ld_i.value;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_q[0] <= `IMND_PTR_RESET;
      ptr_q[1] <= `IMND_PTR_RESET;
      wr_q <= '0;
      pc_inc_q <= 1'b0;
    end
    else
    begin
      ptr_q[0] <= ptr_d[0];
      ptr_q[1] <= ptr_d[1];
      wr_q <= wr_d;
      pc_inc_q <= pc_inc_d;
    end
  end

  assign wr_o = wr_q;
  assign pc_inc_o = pc_inc_q;
  assign ptr0_o = ptr_q[0];
  assign ptr1_o = ptr_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic ind0_go;
  assign ind0_go = instr_i.valid && !ptr_ld_i.valid
                   && kind_of(instr_i.word) == IMND_INDMODE
                   && !instr_i.word[`IMND_INDMODE_SEL_BIT];

  property p_post_inc;
    @(posedge mclk_i) disable iff (rst_i)
    ind0_go && instr_i.word[1:0] == 2'h2 |=>
      wr_o.we && wr_o.addr == $past(ptr_q[0]) && ptr_q[0] == $past(ptr_q[0]) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-increment store wrong"); // RQ1

  property p_post_dec;
    @(posedge mclk_i) disable iff (rst_i)
    ind0_go && instr_i.word[1:0] == 2'h3 |=>
      wr_o.we && wr_o.addr == $past(ptr_q[0]) && ptr_q[0] == $past(ptr_q[0]) - 16'h0001;
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-decrement store wrong"); // RQ1

  property p_indf;
    @(posedge mclk_i) disable iff (rst_i)
    instr_i.valid && kind_of(instr_i.word) == IMND_DIRECT && instr_i.word[6:0] == 7'h01 |=>
      wr_o.we && !wr_o.file_space && wr_o.addr == $past(ptr_q[1]);
  endproperty
  a_indf: assert property (p_indf) else $error("indirect access register not redirected"); // RQ2

  property p_wrap;
    @(posedge mclk_i) disable iff (rst_i)
    ind0_go && instr_i.word[1:0] == 2'h0 && ptr_q[0] == 16'hFFFF |=>
      ptr_q[0] == 16'h0000 && wr_o.addr == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // RQ3

  property p_direct;
    @(posedge mclk_i) disable iff (rst_i)
    instr_i.valid && kind_of(instr_i.word) == IMND_DIRECT && instr_i.word[6:1] != 6'h00 |=>
      wr_o.we && wr_o.file_space && wr_o.addr[6:0] == $past(instr_i.word[6:0])
      && wr_o.addr[15:7] == 9'h000 && wr_o.data == $past(instr_i.w_val) && pc_inc_o;
  endproperty
  a_direct: assert property (p_direct) else $error("direct store wrong"); // RQ4

  property p_pre_dec;
    @(posedge mclk_i) disable iff (rst_i)
    ind0_go && instr_i.word[1:0] == 2'h1 |=>
      wr_o.we && ptr_q[0] == $past(ptr_q[0]) - 16'h0001 && wr_o.addr == ptr_q[0];
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement store wrong"); // RQ5

  property p_relative;
    @(posedge mclk_i) disable iff (rst_i)
    instr_i.valid && !ptr_ld_i.valid && kind_of(instr_i.word) == IMND_RELATIVE
      && !instr_i.word[6] |=>
      $stable(ptr_q[0]) && $stable(ptr_q[1]) && wr_o.we
      && wr_o.addr == $past(ptr_q[0]) + {{10{$past(instr_i.word[5])}}, $past(instr_i.word[5:0])};
  endproperty
  a_relative: assert property (p_relative) else $error("relative store wrong"); // RQ5

  property p_nop;
    @(posedge mclk_i) disable iff (rst_i)
    instr_i.valid && !ptr_ld_i.valid && instr_i.word == 14'h0000 |=>
      !wr_o.we && pc_inc_o && $stable(ptr_q[0]) && $stable(ptr_q[1])
      ##1 (!pc_inc_o || $past(instr_i.valid));
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state"); // RQ6
endmodule

// file: imnd_consts.svh
// Constants for the indirect move and no-operation decode slice.
`ifndef IMND_CONSTS_SVH
`define IMND_CONSTS_SVH

`define IMND_WORD_W 14
`define IMND_PTR_W 16
`define IMND_DATA_W 8
`define IMND_FILE_W 7
`define IMND_NOOP_WORD 14'h0000
`define IMND_DIRECT_PFX 7'h01
`define IMND_DIRECT_MSB 13
`define IMND_DIRECT_LSB 7
`define IMND_INDMODE_PFX 11'h003
`define IMND_INDMODE_MSB 13
`define IMND_INDMODE_LSB 3
`define IMND_INDMODE_SEL_BIT 2
`define IMND_RELATIVE_PFX 7'h7F
`define IMND_RELATIVE_SEL_BIT 6
`define IMND_OFFSET_W 6
`define IMND_ALIAS0_ADDR 7'h00
`define IMND_ALIAS1_ADDR 7'h01
`define IMND_MODE_PREINC 2'h0
`define IMND_MODE_PREDEC 2'h1
`define IMND_MODE_POSTINC 2'h2
`define IMND_MODE_POSTDEC 2'h3
`define IMND_PTR_RESET 16'h0000
`define IMND_PTR_ONE 16'h0001

`endif

// file: imnd_pkg.sv
// Types for the indirect move and no-operation decode slice.
package imnd_pkg;
  `include "imnd_consts.svh"

  typedef struct packed {
    logic valid;
    logic [`IMND_WORD_W-1:0] word;
    logic [`IMND_DATA_W-1:0] w_val;
  } imnd_instr_t;

  typedef struct packed {
    logic valid;
    logic sel;
    logic [`IMND_PTR_W-1:0] value;
  } imnd_ptr_load_t;

  typedef struct packed {
    logic we;
    logic file_space;
    logic [`IMND_PTR_W-1:0] addr;
    logic [`IMND_DATA_W-1:0] data;
  } imnd_mem_wr_t;

  typedef enum {
    IMND_OTHER,
    IMND_NOOP,
    IMND_DIRECT,
    IMND_INDMODE,
    IMND_RELATIVE
  } imnd_kind_t;
endpackage

// file: imnd_decode_tb_top.sv
// Self-checking bench for the indirect move and no-operation decode slice.
`timescale 1ns/1ps
`include "imnd_consts.svh"

module imnd_decode_tb_top;
  import imnd_pkg::*;

  typedef struct packed {
    logic we;
    logic fs;
    logic [15:0] addr;
    logic [7:0] data;
    logic [15:0] p0;
    logic [15:0] p1;
  } imnd_exp_t;

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  imnd_instr_t instr_i = '0;
  imnd_ptr_load_t ptr_ld_i = '0;
  imnd_mem_wr_t wr_o;
  logic pc_inc_o;
  logic [15:0] ptr0_o;
  logic [15:0] ptr1_o;
  imnd_exp_t exp_q[$];
  imnd_exp_t mon_e;
  logic [15:0] m_ptr [2];
  logic [31:0] r;
  logic [13:0] wd;
  integer n_errors = 0;
  integer compares = 0;
  integer seed = 9446;
  integer i;

  always #10 mclk_i = ~mclk_i;

  imnd_decode imnd_decode_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .instr_i(instr_i),
    .ptr_ld_i(ptr_ld_i),
    .wr_o(wr_o),
    .pc_inc_o(pc_inc_o),
    .ptr0_o(ptr0_o),
    .ptr1_o(ptr1_o)
  );

  //////////////////////////////////////////////////////////////////////////////

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Drives one cycle and notes the result that the slice must show one edge later.
  task automatic issue(input logic v, input logic [13:0] w, input logic [7:0] d,
                       input logic ld, input logic sel, input logic [15:0] val);
    imnd_exp_t e;
    logic [15:0] p;
    logic rec;
    @(negedge mclk_i);
    instr_i <= '{v, w, d};
    ptr_ld_i <= '{ld, sel, val};
    e = '0;
    e.we = 1'b1;
    e.data = d;
    rec = v;
    if (!v)
      rec = 1'b0;
    else if (w == `IMND_NOOP_WORD)
      e.we = 1'b0;
    else if (w[13:7] == `IMND_DIRECT_PFX)
    begin
      e.fs = (w[6:1] != 6'h00);
      e.addr = e.fs ? {9'h000, w[6:0]} : m_ptr[w[0]];
    end
    else if (w[13:3] == `IMND_INDMODE_PFX)
    begin
      p = m_ptr[w[2]];
      e.addr = (w[1:0] == 2'h0) ? p + 16'h0001 : (w[1:0] == 2'h1) ? p - 16'h0001 : p;
      m_ptr[w[2]] = w[0] ? p - 16'h0001 : p + 16'h0001;
    end
    else if (w[13:7] == `IMND_RELATIVE_PFX)
      e.addr = m_ptr[w[6]] + {{10{w[5]}}, w[5:0]};
    else
      rec = 1'b0;
    if (ld)
      m_ptr[sel] = val;
    e.p0 = m_ptr[0];
    e.p1 = m_ptr[1];
    if (rec)
      exp_q.push_back(e);
  endtask

  // Outputs are registered, so they are looked at just after each rising edge.
  always @(posedge mclk_i)
  begin
    #1;
    if (pc_inc_o === 1'b1 && exp_q.size() > 0)
    begin
      mon_e = exp_q.pop_front();
      chk("we", wr_o.we, mon_e.we);
      if (mon_e.we)
      begin
        chk("file_space", wr_o.file_space, mon_e.fs);
        chk("addr", wr_o.addr, mon_e.addr);
        chk("data", wr_o.data, mon_e.data);
      end
      chk("ptr0", ptr0_o, mon_e.p0);
      chk("ptr1", ptr1_o, mon_e.p1);
    end
    else
    begin
      chk("pc_inc", pc_inc_o, 16'h0000);
      chk("we_idle", wr_o.we, 16'h0000);
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  initial
  begin
    m_ptr[0] = 16'h0000;
    m_ptr[1] = 16'h0000;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i <= 1'b0;
    chk("ptr0_rst", ptr0_o, 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      issue(1'b0, 14'h0000, 8'h00, 1'b1, i[2], i[0] ? 16'h0000 : 16'hFFFF);
      issue(1'b1, {11'h003, i[2:0]}, 8'($random(seed)), 1'b0, 1'b0, 16'h0000);
      issue(1'b1, {11'h003, i[2:0]}, 8'($random(seed)), 1'b0, 1'b0, 16'h0000);
    end
    $display("Pointer modes and wrap done");
    for (i = 0; i < 6; i++)
    begin
      r = $random(seed);
      wd = {`IMND_DIRECT_PFX, (i < 2) ? 7'(i) : (i == 2) ? 7'h7F : r[6:0]};
      issue(1'b1, wd, r[15:8], 1'b0, 1'b0, 16'h0000);
      issue(1'b1, {`IMND_RELATIVE_PFX, i[0], (i < 2) ? 6'h20 : (i < 4) ? 6'h1F : r[21:16]},
            r[29:22], 1'b0, 1'b0, 16'h0000);
    end
    $display("Direct and relative stores done");
    issue(1'b1, `IMND_NOOP_WORD, 8'h5A, 1'b0, 1'b0, 16'h0000);
    issue(1'b1, 14'h0100, 8'h11, 1'b0, 1'b0, 16'h0000);
    issue(1'b1, 14'h0020, 8'h22, 1'b0, 1'b0, 16'h0000);
    issue(1'b0, 14'h0085, 8'h33, 1'b0, 1'b0, 16'h0000);
    issue(1'b1, `IMND_NOOP_WORD, 8'h44, 1'b0, 1'b0, 16'h0000);
    issue(1'b1, 14'h001A, 8'h4F, 1'b1, 1'b0, 16'h1234);
    issue(1'b1, 14'h001F, 8'h50, 1'b1, 1'b0, 16'h8000);
    $display("No-operation, ignored words and load priority done");
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      case (r[1:0])
        2'h0: wd = {`IMND_DIRECT_PFX, r[8:2]};
        2'h1: wd = {`IMND_INDMODE_PFX, r[4:2]};
        2'h2: wd = {`IMND_RELATIVE_PFX, r[8:2]};
        default: wd = `IMND_NOOP_WORD;
      endcase
      issue(1'b1, wd, r[23:16], r[24] & r[25], r[26], r[31:16]);
    end
    $display("Random back-to-back mix done");
    @(negedge mclk_i);
    instr_i <= '0;
    ptr_ld_i <= '0;
    repeat (3) @(negedge mclk_i);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
